//--- verilog/adc_result_regs.sv
// Result register bank for converter channels 9 to E behind an AXI4-Lite slave.
// Assumes the converter core runs on clk and reports each finished conversion
// with a one-cycle valid carrying channel number and 10-bit value.
//
// Overview of operation
// - Low byte carries result bits 1..0 in bits 7..6; bits 5..0 read zero.
// - High byte carries result bits 9..2 in bits 7..0.
// - Both bytes of a channel load when its conversion completes, then hold.
// - One low/high pair per channel 9..E at consecutive addresses, low even.
// - Low byte resets to zero; wide read returns low with its paired high.
// - High byte resets to zero and is read as a single byte only.
`timescale 1ns/100ps
`include "adc_result_params.svh"

module adc_result_regs
	import adc_result_pkg::*;
(
	input  wire logic                       clk,
	input  wire logic                       reset,
	input  wire logic                       ce,
	input  conv_done_t                      convDone,
	input  wire logic [`ADC_AXI_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [`ADC_AXI_DATA_W-1:0] s_axi_wdata,
	input  wire logic [`ADC_AXI_STRB_W-1:0] s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [`ADC_AXI_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [`ADC_AXI_DATA_W-1:0]      s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready
);

	localparam int NCH = `ADC_RESULT_NUM_CHAN;
	localparam int IDXW = `ADC_AXI_ADDR_W - 2;

	// Each register owns one bus word; its byte address is four times its index.
	localparam logic [IDXW-1:0] LOW_IDX [NCH] = '{
		`ADC_RESULT_CH9_LOW_IDX,
		`ADC_RESULT_CHA_LOW_IDX,
		`ADC_RESULT_CHB_LOW_IDX,
		`ADC_RESULT_CHC_LOW_IDX,
		`ADC_RESULT_CHD_LOW_IDX,
		`ADC_RESULT_CHE_LOW_IDX
	};
	localparam logic [IDXW-1:0] HIGH_IDX [NCH] = '{
		`ADC_RESULT_CH9_HIGH_IDX,
		`ADC_RESULT_CHA_HIGH_IDX,
		`ADC_RESULT_CHB_HIGH_IDX,
		`ADC_RESULT_CHC_HIGH_IDX,
		`ADC_RESULT_CHD_HIGH_IDX,
		`ADC_RESULT_CHE_HIGH_IDX
	};
	localparam logic [IDXW-1:0] FLAGS_IDX = `ADC_RESULT_NEW_FLAGS_IDX;

	// Converter side: one holder per channel.

	result_pair_t         pairs [NCH];
	logic [NCH-1:0]       loadVec;

	// A completion on a channel outside 9..E matches no holder and is dropped.
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			loadVec[i] = convDone.valid &&
				(convDone.chan == (`ADC_RESULT_FIRST_CHAN + 4'(i)));
		end
	end

	adc_result_channel chan9_inst (
		.clk   (clk),
		.reset (reset),
		.ce    (ce),
		.load  (loadVec[0]),
		.value (convDone.value),
		.pair  (pairs[0])
	);

	adc_result_channel chana_inst (
		.clk   (clk),
		.reset (reset),
		.ce    (ce),
		.load  (loadVec[1]),
		.value (convDone.value),
		.pair  (pairs[1])
	);

	adc_result_channel chanb_inst (
		.clk   (clk),
		.reset (reset),
		.ce    (ce),
		.load  (loadVec[2]),
		.value (convDone.value),
		.pair  (pairs[2])
	);

	adc_result_channel chanc_inst (
		.clk   (clk),
		.reset (reset),
		.ce    (ce),
		.load  (loadVec[3]),
		.value (convDone.value),
		.pair  (pairs[3])
	);

	adc_result_channel chand_inst (
		.clk   (clk),
		.reset (reset),
		.ce    (ce),
		.load  (loadVec[4]),
		.value (convDone.value),
		.pair  (pairs[4])
	);

	adc_result_channel chane_inst (
		.clk   (clk),
		.reset (reset),
		.ce    (ce),
		.load  (loadVec[5]),
		.value (convDone.value),
		.pair  (pairs[5])
	);

	// Write channel state.

	logic                  awready_r;
	logic                  awready_nxt;
	logic                  wready_r;
	logic                  wready_nxt;
	logic                  awHeld_r;
	logic                  awHeld_nxt;
	logic                  wHeld_r;
	logic                  wHeld_nxt;
	logic [IDXW-1:0]       awIdx_r;
	logic [IDXW-1:0]       awIdx_nxt;
	logic [NCH-1:0]        wClr_r;
	logic [NCH-1:0]        wClr_nxt;
	logic                  bvalid_r;
	logic                  bvalid_nxt;
	axi_resp_t             bresp_r;
	axi_resp_t             bresp_nxt;
	logic [NCH-1:0]        flags_r;
	logic [NCH-1:0]        flags_nxt;

	logic                  awTake;
	logic                  wTake;
	logic                  doWrite;
	logic                  wrMapped;
	logic [IDXW-1:0]       wrIdx;
	logic [NCH-1:0]        wrClr;
	logic [NCH-1:0]        flagClr;

	always_comb begin
		awTake   = s_axi_awvalid && awready_r;
		wTake    = s_axi_wvalid && wready_r;
		wrIdx    = awTake ? s_axi_awaddr[`ADC_AXI_ADDR_W-1:2] : awIdx_r;
		wrClr    = wTake ? (s_axi_wstrb[0] ? s_axi_wdata[NCH-1:0] : '0) : wClr_r;
		awHeld_nxt = awHeld_r || awTake;
		wHeld_nxt  = wHeld_r || wTake;
		awIdx_nxt  = wrIdx;
		wClr_nxt   = wrClr;
		// Address and data may arrive in either order; the answer waits for both.
		doWrite  = awHeld_nxt && wHeld_nxt && !bvalid_r;
		wrMapped = (wrIdx == FLAGS_IDX);
		for (int i = 0; i < NCH; i++) begin
			if (wrIdx == LOW_IDX[i] || wrIdx == HIGH_IDX[i]) begin
				wrMapped = 1'b1;
			end
		end
		if (doWrite) begin
			awHeld_nxt = 1'b0;
			wHeld_nxt  = 1'b0;
		end
		bvalid_nxt = doWrite || (bvalid_r && !s_axi_bready);
		// Result registers accept the write but nothing in them changes.
		bresp_nxt  = doWrite ? (wrMapped ? RESP_OKAY : RESP_DECERR) : bresp_r;
		awready_nxt = !awHeld_nxt && !bvalid_nxt;
		wready_nxt  = !wHeld_nxt && !bvalid_nxt;
		flagClr = (doWrite && wrIdx == FLAGS_IDX) ? wrClr : '0;
		// A completion landing with its clear keeps the flag set.
		flags_nxt = (flags_r & ~flagClr) | loadVec;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			awready_r <= 1'b0;
			wready_r  <= 1'b0;
			awHeld_r  <= 1'b0;
			wHeld_r   <= 1'b0;
			awIdx_r   <= '0;
			wClr_r    <= '0;
			bvalid_r  <= 1'b0;
			bresp_r   <= RESP_OKAY;
			flags_r   <= `ADC_NEW_FLAGS_RESET;
		end else if (ce) begin
			awready_r <= awready_nxt;
			wready_r  <= wready_nxt;
			awHeld_r  <= awHeld_nxt;
			wHeld_r   <= wHeld_nxt;
			awIdx_r   <= awIdx_nxt;
			wClr_r    <= wClr_nxt;
			bvalid_r  <= bvalid_nxt;
			bresp_r   <= bresp_nxt;
			flags_r   <= flags_nxt;
		end
	end

	// Read channel state.

	logic                       arready_r;
	logic                       arready_nxt;
	logic                       rvalid_r;
	logic                       rvalid_nxt;
	logic [`ADC_AXI_DATA_W-1:0] rdata_r;
	logic [`ADC_AXI_DATA_W-1:0] rdata_nxt;
	axi_resp_t                  rresp_r;
	axi_resp_t                  rresp_nxt;

	logic                       arTake;
	logic [IDXW-1:0]            rdIdx;
	logic [`ADC_AXI_DATA_W-1:0] rdWord;
	axi_resp_t                  rdResp;

	always_comb begin
		arTake = s_axi_arvalid && arready_r;
		rdIdx  = s_axi_araddr[`ADC_AXI_ADDR_W-1:2];
		rdWord = '0;
		rdResp = RESP_OKAY;
		// Byte lane 0 serves a byte read, lanes 1..0 a halfword read of a low register.
		// A high register fills lane 0 only, so a wider read sees zeros above it.
		unique case (rdIdx)
			`ADC_RESULT_CH9_LOW_IDX: begin
				rdWord = {16'h0000, pairs[0].high, pairs[0].low};
			end
			`ADC_RESULT_CH9_HIGH_IDX: begin
				rdWord = {24'h000000, pairs[0].high};
			end
			`ADC_RESULT_CHA_LOW_IDX: begin
				rdWord = {16'h0000, pairs[1].high, pairs[1].low};
			end
			`ADC_RESULT_CHA_HIGH_IDX: begin
				rdWord = {24'h000000, pairs[1].high};
			end
			`ADC_RESULT_CHB_LOW_IDX: begin
				rdWord = {16'h0000, pairs[2].high, pairs[2].low};
			end
			`ADC_RESULT_CHB_HIGH_IDX: begin
				rdWord = {24'h000000, pairs[2].high};
			end
			`ADC_RESULT_CHC_LOW_IDX: begin
				rdWord = {16'h0000, pairs[3].high, pairs[3].low};
			end
			`ADC_RESULT_CHC_HIGH_IDX: begin
				rdWord = {24'h000000, pairs[3].high};
			end
			`ADC_RESULT_CHD_LOW_IDX: begin
				rdWord = {16'h0000, pairs[4].high, pairs[4].low};
			end
			`ADC_RESULT_CHD_HIGH_IDX: begin
				rdWord = {24'h000000, pairs[4].high};
			end
			`ADC_RESULT_CHE_LOW_IDX: begin
				rdWord = {16'h0000, pairs[5].high, pairs[5].low};
			end
			`ADC_RESULT_CHE_HIGH_IDX: begin
				rdWord = {24'h000000, pairs[5].high};
			end
			`ADC_RESULT_NEW_FLAGS_IDX: begin
				rdWord = {{(`ADC_AXI_DATA_W-NCH){1'b0}}, flags_r};
			end
			default: begin
				// Nothing lives here; the master sees zeros and a decode error.
				rdResp = RESP_DECERR;
			end
		endcase
		rvalid_nxt  = arTake || (rvalid_r && !s_axi_rready);
		arready_nxt = !rvalid_nxt;
		rdata_nxt   = arTake ? rdWord : rdata_r;
		rresp_nxt   = arTake ? rdResp : rresp_r;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			arready_r <= 1'b0;
			rvalid_r  <= 1'b0;
			rdata_r   <= '0;
			rresp_r   <= RESP_OKAY;
		end else if (ce) begin
			arready_r <= arready_nxt;
			rvalid_r  <= rvalid_nxt;
			rdata_r   <= rdata_nxt;
			rresp_r   <= rresp_nxt;
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready  = wready_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;

endmodule

//--- inc/adc_result_params.svh
// Constants for the conversion result register bank: register indices,
// field positions, reset values and bus widths.
// Assumes it is included by bare name from the package and the design files.
`ifndef ADC_RESULT_PARAMS_SVH
`define ADC_RESULT_PARAMS_SVH

// Register indices; the bus byte address is four times the index.
`define ADC_RESULT_CH9_LOW_IDX  16'hf2e2
`define ADC_RESULT_CH9_HIGH_IDX 16'hf2e3
`define ADC_RESULT_CHA_LOW_IDX  16'hf2e4
`define ADC_RESULT_CHA_HIGH_IDX 16'hf2e5
`define ADC_RESULT_CHB_LOW_IDX  16'hf2e6
`define ADC_RESULT_CHB_HIGH_IDX 16'hf2e7
`define ADC_RESULT_CHC_LOW_IDX  16'hf2e8
`define ADC_RESULT_CHC_HIGH_IDX 16'hf2e9
`define ADC_RESULT_CHD_LOW_IDX  16'hf2ea
`define ADC_RESULT_CHD_HIGH_IDX 16'hf2eb
`define ADC_RESULT_CHE_LOW_IDX  16'hf2ec
`define ADC_RESULT_CHE_HIGH_IDX 16'hf2ed
`define ADC_RESULT_NEW_FLAGS_IDX 16'hf2fe

// Converter channels held by this bank: 9 up to E.
`define ADC_RESULT_FIRST_CHAN 4'h9
`define ADC_RESULT_NUM_CHAN   6

// Conversion result and its split over the two bytes.
`define ADC_RESULT_WIDTH     10
`define ADC_LOW_FIELD_MSB    7
`define ADC_LOW_FIELD_LSB    6
`define ADC_HIGH_FIELD_MSB   7
`define ADC_HIGH_FIELD_LSB   0
`define ADC_RESULT_SPLIT_BIT 2
`define ADC_RESULT_RESET     8'h00
`define ADC_NEW_FLAGS_RESET  6'h00

// Register bus.
`define ADC_AXI_ADDR_W 18
`define ADC_AXI_DATA_W 32
`define ADC_AXI_STRB_W 4

`endif

//--- inc/adc_result_pkg.sv
// Types shared by the result register bank and its channel holders.
// Assumes the constants header sits on the include path.
`include "adc_result_params.svh"

package adc_result_pkg;

	// One finished conversion as handed over by the converter core.
	typedef struct packed {
		logic                          valid;
		logic [3:0]                    chan;
		logic [`ADC_RESULT_WIDTH-1:0]  value;
	} conv_done_t;

	// Low and high result bytes of one channel.
	typedef struct packed {
		logic [7:0] high;
		logic [7:0] low;
	} result_pair_t;

	typedef enum logic [1:0] {
		RESP_OKAY   = 2'b00,
		RESP_DECERR = 2'b11
	} axi_resp_t;

endpackage

//--- verilog/adc_result_channel.sv
// Holds the split conversion result of one converter channel.
// Assumes load is a one-cycle pulse on the same clock as the result value.
`timescale 1ns/100ps
`include "adc_result_params.svh"

module adc_result_channel
	import adc_result_pkg::*;
(
	input  wire logic                         clk,
	input  wire logic                         reset,
	input  wire logic                         ce,
	input  wire logic                         load,
	input  wire logic [`ADC_RESULT_WIDTH-1:0] value,
	output result_pair_t                      pair
);

	result_pair_t pair_r;
	result_pair_t pair_nxt;

	always_comb begin
		pair_nxt = pair_r;
		if (load) begin
			pair_nxt.low  = `ADC_RESULT_RESET;
			pair_nxt.low[`ADC_LOW_FIELD_MSB:`ADC_LOW_FIELD_LSB] =
				value[`ADC_RESULT_SPLIT_BIT-1:0];
			pair_nxt.high[`ADC_HIGH_FIELD_MSB:`ADC_HIGH_FIELD_LSB] =
				value[`ADC_RESULT_WIDTH-1:`ADC_RESULT_SPLIT_BIT];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			pair_r.low  <= `ADC_RESULT_RESET;
			pair_r.high <= `ADC_RESULT_RESET;
		end else if (ce) begin
			pair_r <= pair_nxt;
		end
	end

	assign pair = pair_r;

endmodule

//--- verification/adc_result_regs_sva.sv
// Checker for the result register bank, watching the top-level ports only.
// Assumes one clock domain and the register indices of the bank's header.
`timescale 1ns/100ps
`include "adc_result_params.svh"
module adc_result_regs_sva
	import adc_result_pkg::*;
(
	input wire logic	clk,
	input wire logic	reset,
	input wire logic	ce,
	input conv_done_t	convDone,
	input wire logic [17:0]	s_axi_awaddr,
	input wire logic	s_axi_awvalid,
	input wire logic	s_axi_awready,
	input wire logic [1:0]	s_axi_bresp,
	input wire logic	s_axi_bvalid,
	input wire logic	s_axi_bready,
	input wire logic [17:0]	s_axi_araddr,
	input wire logic	s_axi_arvalid,
	input wire logic	s_axi_arready,
	input wire logic [31:0]	s_axi_rdata,
	input wire logic [1:0]	s_axi_rresp,
	input wire logic	s_axi_rvalid,
	input wire logic	s_axi_rready
);
	logic [15:0]	rIdx;
	logic [15:0]	wIdx;
	logic		arTake;
	logic		rRes;
	logic		wRes;
	logic [9:0]	ch9Value_r;
	assign rIdx = s_axi_araddr[17:2];
	assign wIdx = s_axi_awaddr[17:2];
	assign arTake = s_axi_arvalid && s_axi_arready && ce;
	assign rRes = rIdx >= `ADC_RESULT_CH9_LOW_IDX && rIdx <= `ADC_RESULT_CHE_HIGH_IDX;
	assign wRes = wIdx >= `ADC_RESULT_CH9_LOW_IDX && wIdx <= `ADC_RESULT_CHE_HIGH_IDX;
	// Mirror of channel 9, so that a read can be tied to the conversion that fed it.
	always_ff @(posedge clk) begin
		if (reset)
			ch9Value_r <= 10'h000;
		else if (ce && convDone.valid && convDone.chan == 4'h9)
			ch9Value_r <= convDone.value;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	chk_low_pad: assert property (arTake && rRes && !rIdx[0]
		|=> s_axi_rdata[31:16] == 16'h0000 && s_axi_rdata[5:0] == 6'h00)
		else $error("low byte word carries stray bits");
	chk_high_only: assert property (arTake && rRes && rIdx[0]
		|=> s_axi_rdata[31:8] == 24'h000000) else $error("high byte read is wider than a byte");
	chk_unmapped_err: assert property (arTake && !rRes && rIdx != 16'hf2fe
		|=> s_axi_rvalid && s_axi_rresp == 2'b11 && s_axi_rdata == 32'h0) else $error("bad unmapped read");
	chk_ch9_low: assert property (arTake && rIdx == `ADC_RESULT_CH9_LOW_IDX
		|=> s_axi_rdata[15:0] == {$past(ch9Value_r), 6'h00}) else $error("ch9 pair wrong");
	chk_ch9_high: assert property (arTake && rIdx == `ADC_RESULT_CH9_HIGH_IDX
		|=> s_axi_rdata == {24'h0, $past(ch9Value_r[9:2])}) else $error("ch9 high byte wrong");
	chk_wr_ignored: assert property (s_axi_awvalid && s_axi_awready && ce && wRes
		|-> ##[1:20] s_axi_bvalid && s_axi_bresp == 2'b00) else $error("result write not answered okay");
	chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped early");
	cover property (s_axi_rvalid && s_axi_rready);
	cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'b11);
	cover property (ce && convDone.valid);
endmodule
bind adc_result_regs adc_result_regs_sva adc_result_regs_sva_inst (
	.clk(clk), .reset(reset), .ce(ce), .convDone(convDone), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

//--- verification/conv_core_model.sv
// Behavioural converter core: finishes one conversion a chosen number of cycles after start.
// Assumes the same clock as the bank and a start pulse of one cycle.
`timescale 1ns/100ps
module conv_core_model
	import adc_result_pkg::*;
(
	input  wire logic	clk,
	input  wire logic	reset,
	input  wire logic	start,
	input  wire logic [3:0]	chanIn,
	input  wire logic [9:0]	valueIn,
	input  wire logic [3:0]	delayIn,
	output conv_done_t	convDone
);
	logic		busy;
	logic [3:0]	cnt;
	conv_done_t	pend;
	always @(posedge clk) begin
		if (reset) begin
			busy <= 1'b0;
			convDone <= '0;
		end else begin
			// Idle payload is inverted each cycle so that stale values never look valid.
			convDone <= {1'b0, ~convDone.chan, ~convDone.value};
			if (start) begin
				busy <= 1'b1;
				cnt <= delayIn;
				pend <= {1'b1, chanIn, valueIn};
			end else if (busy && cnt == 4'h0) begin
				busy <= 1'b0;
				convDone <= pend;
			end else if (busy)
				cnt <= cnt - 4'h1;
		end
	end
endmodule

//--- verification/tb_adc_result_regs.sv
// Self-checking bench for the result register bank over its register bus.
// Assumes the converter model and the checker file are compiled alongside.
`timescale 1ns/100ps
`include "adc_result_params.svh"
module tb_adc_result_regs;
	import adc_result_pkg::*;
	typedef struct packed {
		logic [3:0]	chan;
		logic [9:0]	val;
		logic [31:0]	lowW;
		logic [31:0]	highW;
	} row_t;
	logic		clk, reset, ce, start, awvalid, awready, wvalid, wready, bvalid, bready;
	logic		arvalid, arready, rvalid, rready;
	logic [3:0]	chanIn, delayIn, wstrb;
	logic [9:0]	valueIn;
	logic [17:0]	awaddr, araddr;
	logic [31:0]	wdata, rdata, d;
	logic [1:0]	bresp, rresp, r;
	conv_done_t	convDone;
	int		fails, nCompared, wt, i;
	row_t		rows [6] = '{'{4'h9, 10'h3ff, 32'hffc0, 32'hff}, '{4'ha, 10'h001, 32'h40, 32'h0},
		'{4'hb, 10'h2aa, 32'haa80, 32'haa}, '{4'hc, 10'h155, 32'h5540, 32'h55},
		'{4'hd, 10'h200, 32'h8000, 32'h80}, '{4'he, 10'h003, 32'hc0, 32'h0}};
	localparam logic [15:0] BASE = `ADC_RESULT_CH9_LOW_IDX;
	adc_result_regs adc_result_regs_inst (.clk(clk), .reset(reset), .ce(ce), .convDone(convDone),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	conv_core_model conv_core_model_inst (.clk(clk), .reset(reset), .start(start),
		.chanIn(chanIn), .valueIn(valueIn), .delayIn(delayIn), .convDone(convDone));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic finish_test();
		$display("compared %0d, mismatched %0d", nCompared, fails);
		if (fails == 0 && nCompared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic tick();
		@(posedge clk);
		wt++;
		if (wt > 200) begin
			fails++;
			finish_test();
		end
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		nCompared++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h, want %h", $time, seen, exp);
		end
	endtask
	task automatic axRead(input logic [15:0] idx);
		wt = 0;
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do tick(); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do tick(); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge clk);
	endtask
	task automatic axWrite(input logic [15:0] idx, input logic [31:0] v);
		logic a, w;
		a = 1'b0;
		w = 1'b0;
		wt = 0;
		awaddr <= {idx, 2'b00};
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(a && w)) begin
			tick();
			if (awready === 1'b1 && !a) begin
				a = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready === 1'b1 && !w) begin
				w = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do tick(); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
		@(posedge clk);
	endtask
	task automatic convert(input logic [3:0] c, input logic [9:0] v, input logic [3:0] dl);
		wt = 0;
		start <= 1'b1;
		chanIn <= c;
		valueIn <= v;
		delayIn <= dl;
		tick();
		start <= 1'b0;
		do tick(); while (convDone.valid !== 1'b1);
		tick();
	endtask
	initial begin
		{fails, nCompared} = 0;
		{reset, ce} <= 2'b11;
		{start, awvalid, wvalid, bready, arvalid, rready} <= 6'h00;
		{chanIn, delayIn, valueIn, awaddr, araddr, wdata} <= '0;
		wstrb <= 4'hf;
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		for (i = 0; i < 6; i++) begin
			convert(rows[i].chan, rows[i].val, 4'(i * 3));
			axRead(BASE + 16'(2 * i));
			chk(d, rows[i].lowW);
			chk(32'(r), 32'h0);
			axRead(BASE + 16'(2 * i + 1));
			chk(d, rows[i].highW);
		end
		axRead(BASE);
		chk(d, rows[0].lowW);
		axRead(`ADC_RESULT_NEW_FLAGS_IDX);
		chk(d, 32'h3f);
		wstrb <= 4'he;
		axWrite(`ADC_RESULT_NEW_FLAGS_IDX, 32'h3f);
		axRead(`ADC_RESULT_NEW_FLAGS_IDX);
		chk(d, 32'h3f);
		wstrb <= 4'hf;
		axWrite(`ADC_RESULT_NEW_FLAGS_IDX, 32'h01);
		axRead(`ADC_RESULT_NEW_FLAGS_IDX);
		chk(d, 32'h3e);
		for (i = 0; i < 2; i++) begin
			axWrite(BASE + 16'(i), 32'hffffffff);
			chk(32'(r), 32'h0);
			axRead(BASE + 16'(i));
			chk(d, i == 0 ? rows[0].lowW : rows[0].highW);
		end
		axRead(16'hf2f0);
		chk({d[29:0], r}, 32'h3);
		axWrite(16'hf2f0, 32'h1);
		chk(32'(r), 32'h3);
		ce <= 1'b0;
		convert(4'h9, 10'h000, 4'h0);
		ce <= 1'b1;
		convert(4'h8, 10'h000, 4'h0);
		axRead(BASE);
		chk(d, rows[0].lowW);
		convert(4'h9, 10'h155, 4'h0);
		axRead(BASE);
		chk(d, 32'h5540);
		reset <= 1'b1;
		@(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		axRead(BASE);
		chk(d, 32'h0);
		axRead(BASE + 16'h1);
		chk(d, 32'h0);
		finish_test();
	end
endmodule
